//--- hw/pid_map.svh
// register map, field positions and reset values of the pen and contrast control slice
`ifndef PID_MAP_SVH
`define PID_MAP_SVH
`define PID_WORD_BITS 16
`define PID_ADDR_MSB 15
`define PID_ADDR_LSB 12
`define PID_DATA_MSB 11
`define PID_DAC_CTRL_ADDR 4'he
`define PID_CTRL1_ADDR 4'h1
`define PID_MODE_MSB 11
`define PID_MODE_LSB 10
`define PID_DAC_TYPE_BIT 2
`define PID_DAC_RANGE_BIT 0
`define PID_DAC_CODE_MSB 11
`define PID_DAC_CODE_LSB 4
`define PID_DAC_RESET 12'h000
`define PID_CTRL1_RESET 12'h000
`define PID_PEN_RESET 1'b1
`define PID_READY_RESET 1'b1
`define PID_TOUCH_RESET 1'b0
`define PID_START_RESET 1'b0
`endif

//--- hw/pid_pkg.sv
// types of the pen and contrast control slice
package pid_pkg;
    typedef enum logic [1:0] {
        PID_MODE_IDLE = 2'b00,
        PID_MODE_SLAVE_A = 2'b01,
        PID_MODE_SLAVE_B = 2'b10,
        PID_MODE_MASTER = 2'b11
    } pid_mode_t;
    typedef struct packed {
        logic voltage_n;
        logic full_range;
        logic [7:0] code;
    } pid_dac_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [11:0] data;
    } pid_word_t;
endpackage

//--- hw/pid_sync.sv
// two flip-flop level synchroniser
module pid_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;
    logic stage2;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end
    assign sync_out = stage2;
endmodule // pid_sync

//--- hw/pid_ctrl.sv
// pen-down request, host sync modes and contrast dac control register
// Functional notes
// - pen-down request idles high, goes low when touch is detected.
// - touch detection is suspended while a conversion runs.
// - touch ends with converter idle: request returns high at once.
// - touch ends while converting: request stays low until converter idle.
// - mode 01 or 10 is slave, mode 11 is master with auto sequencing.
// - in master mode a touch starts the sequence without host command.
// - dac control bit 2 picks voltage (0) or current sink (1).
// - dac control bit 0 picks half (0) or full (1) supply range.
// - write to address 1110 loads the eight data msbs as dac code.
// - a write word is four address bits then twelve data bits.
// - data-available low on fresh results, high on read or timer start.
`include "pid_map.svh"
module pid_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic touch_pin,
    input wire logic wr_valid,
    input wire logic [`PID_WORD_BITS-1:0] wr_word,
    input wire logic conv_busy,
    input wire logic conv_done,
    input wire logic results_read,
    input wire logic timer_start,
    output logic pen_down_request_n,
    output logic results_ready_n,
    output logic start_sequence,
    output logic [1:0] mode,
    output logic dac_current_mode,
    output logic dac_full_range,
    output logic [7:0] dac_code,
    output logic [11:0] dac_ctrl_read
);
    logic touch_s;
    pid_sync pid_sync_inst (
        .clk(clk),
        .rst(rst),
        .async_in(touch_pin),
        .sync_out(touch_s)
    );

    pid_pkg::pid_word_t word;
    assign word = pid_pkg::pid_word_t'(wr_word);

    function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] target);
        addr_hit = (a == target);
    endfunction

    logic pen_n;
    logic next_pen_n;
    logic touch_d;
    logic next_touch_d;
    logic ready_n;
    logic next_ready_n;
    logic start;
    logic next_start;
    logic [11:0] ctrl1;
    logic [11:0] next_ctrl1;
    logic [11:0] dac_reg;
    logic [11:0] next_dac_reg;
    logic master;

    assign master = (pid_pkg::pid_mode_t'(ctrl1[`PID_MODE_MSB:`PID_MODE_LSB])
        == pid_pkg::PID_MODE_MASTER);

    always_comb
    begin
        next_ctrl1 = ctrl1;
        next_dac_reg = dac_reg;
        if (wr_valid && addr_hit(word.addr, `PID_CTRL1_ADDR))
        begin
            next_ctrl1 = word.data;
        end
        else if (wr_valid && addr_hit(word.addr, `PID_DAC_CTRL_ADDR))
        begin
            next_dac_reg = word.data;
        end
    end

    always_comb
    begin
        next_touch_d = touch_d;
        if (!conv_busy)
        begin
            next_touch_d = touch_s;
        end
        next_pen_n = pen_n;
        if (!conv_busy && touch_s)
        begin
            next_pen_n = 1'b0;
        end
        else if (!conv_busy && !touch_s)
        begin
            next_pen_n = 1'b1;
        end
        next_start = master && !conv_busy && touch_s && !touch_d;
    end

    always_comb
    begin
        next_ready_n = ready_n;
        if (results_read || timer_start)
        begin
            next_ready_n = 1'b1;
        end
        if (conv_done)
        begin
            next_ready_n = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl1 <= `PID_CTRL1_RESET;
            dac_reg <= `PID_DAC_RESET;
        end
        else
        begin
            ctrl1 <= next_ctrl1;
            dac_reg <= next_dac_reg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pen_n <= `PID_PEN_RESET;
            touch_d <= `PID_TOUCH_RESET;
            start <= `PID_START_RESET;
        end
        else
        begin
            pen_n <= next_pen_n;
            touch_d <= next_touch_d;
            start <= next_start;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ready_n <= `PID_READY_RESET;
        end
        else
        begin
            ready_n <= next_ready_n;
        end
    end

    assign pen_down_request_n = pen_n;
    assign results_ready_n = ready_n;
    assign start_sequence = start;
    assign mode = ctrl1[`PID_MODE_MSB:`PID_MODE_LSB];
    pid_pkg::pid_dac_t dac_fields;
    assign dac_fields = '{
        voltage_n: dac_reg[`PID_DAC_TYPE_BIT],
        full_range: dac_reg[`PID_DAC_RANGE_BIT],
        code: dac_reg[`PID_DAC_CODE_MSB:`PID_DAC_CODE_LSB]
    };
    assign dac_current_mode = dac_fields.voltage_n;
    assign dac_full_range = dac_fields.full_range;
    assign dac_code = dac_fields.code;
    assign dac_ctrl_read = dac_reg;

    chk_pen_follows_touch: assert property (@(posedge clk) disable iff (rst)
        (!conv_busy && touch_s) |=> !pen_down_request_n)
        else $error("pen request not low after touch");
    chk_pen_release_idle: assert property (@(posedge clk) disable iff (rst)
        (!conv_busy && !touch_s) |=> pen_down_request_n)
        else $error("pen request not released while idle");
    chk_pen_hold_busy: assert property (@(posedge clk) disable iff (rst)
        (conv_busy && !pen_down_request_n) |=> !pen_down_request_n)
        else $error("pen request released during conversion");
    chk_pen_frozen_busy: assert property (@(posedge clk) disable iff (rst)
        conv_busy |=> $stable(pen_down_request_n))
        else $error("pen request moved during conversion");
    chk_master_start: assert property (@(posedge clk) disable iff (rst)
        start_sequence |-> $past(master) && $past(touch_s) && !$past(touch_d))
        else $error("sequence start without master touch");
    chk_dac_write: assert property (@(posedge clk) disable iff (rst)
        (wr_valid && wr_word[15:12] == 4'he) |=> dac_code == $past(wr_word[11:4]))
        else $error("dac code not loaded");
    chk_dac_type: assert property (@(posedge clk) disable iff (rst)
        (wr_valid && wr_word[15:12] == 4'he) |=> dac_current_mode == $past(wr_word[2]))
        else $error("dac type bit wrong");
    chk_dac_range: assert property (@(posedge clk) disable iff (rst)
        (wr_valid && wr_word[15:12] == 4'he) |=> dac_full_range == $past(wr_word[0]))
        else $error("dac range bit wrong");
    chk_ready_set: assert property (@(posedge clk) disable iff (rst)
        conv_done |=> !results_ready_n)
        else $error("results ready not low after done");
    chk_ready_clear: assert property (@(posedge clk) disable iff (rst)
        (!conv_done && (results_read || timer_start)) |=> results_ready_n)
        else $error("results ready not cleared");
    chk_mode_decode: assert property (@(posedge clk) disable iff (rst)
        (mode != 2'b11) |=> !start_sequence)
        else $error("sequence start outside master mode");
    chk_mode_write: assert property (@(posedge clk) disable iff (rst)
        (wr_valid && wr_word[15:12] == 4'h1) |=> mode == $past(wr_word[11:10]))
        else $error("mode field not loaded");
    chk_start_single: assert property (@(posedge clk) disable iff (rst)
        start_sequence |=> !start_sequence)
        else $error("sequence start longer than one cycle");
    chk_start_idle: assert property (@(posedge clk) disable iff (rst)
        start_sequence |-> !$past(conv_busy))
        else $error("sequence start during conversion");
    chk_dac_other: assert property (@(posedge clk) disable iff (rst)
        (wr_valid && wr_word[15:12] != 4'he) |=> $stable(dac_ctrl_read))
        else $error("dac register changed by other address");
    chk_ready_hold: assert property (@(posedge clk) disable iff (rst)
        (!conv_done && !results_read && !timer_start) |=> $stable(results_ready_n))
        else $error("results ready moved without cause");
endmodule // pid_ctrl

//--- tb/pid_conv_model.sv
// converter partner: busy for a fixed span per start, then done pulse
module pid_conv_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    output logic busy,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    always_ff @(posedge clk)
    begin
        done <= 1'b0;
        if (rst)
            cnt <= 4'h0;
        else if (start && cnt == 4'h0)
            cnt <= 4'h8;
        else if (cnt != 4'h0)
        begin
            cnt <= cnt - 4'h1;
            done <= (cnt == 4'h1);
        end
    end
    assign busy = (cnt != 4'h0);
endmodule // pid_conv_model

//--- tb/tb_pid_ctrl.sv
// bench for pen request, mode and contrast register
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_pid_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, touch_pin = 1'b0, wr_valid = 1'b0;
    logic [15:0] wr_word = 16'h0000;
    logic results_read = 1'b0, timer_start = 1'b0, conv_req = 1'b0;
    logic conv_busy, conv_done, pen_n, ready_n, start_seq, dac_cur, dac_full;
    logic [1:0] mode;
    logic [7:0] dac_code;
    logic [11:0] dac_rd;
    int errors = 0, checks = 0, starts = 0;
    initial forever #4 clk = ~clk;
    pid_ctrl pid_ctrl_inst (.clk(clk), .rst(rst), .touch_pin(touch_pin),
        .wr_valid(wr_valid), .wr_word(wr_word), .conv_busy(conv_busy),
        .conv_done(conv_done), .results_read(results_read), .timer_start(timer_start),
        .pen_down_request_n(pen_n), .results_ready_n(ready_n), .start_sequence(start_seq),
        .mode(mode), .dac_current_mode(dac_cur), .dac_full_range(dac_full),
        .dac_code(dac_code), .dac_ctrl_read(dac_rd));
    pid_conv_model pid_conv_model_inst (.clk(clk), .rst(rst), .start(start_seq | conv_req),
        .busy(conv_busy), .done(conv_done));
    always @(posedge clk) if (start_seq === 1'b1) starts++;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] w);
        @(posedge clk) begin wr_valid <= 1'b1; wr_word <= w; end
        @(posedge clk) wr_valid <= 1'b0;
        #1;
    endtask
    task automatic pulse(input int sel);
        @(posedge clk)
        begin
            results_read <= (sel == 0);
            timer_start <= (sel == 1);
            conv_req <= (sel == 2);
        end
        @(posedge clk)
        begin
            results_read <= 1'b0;
            timer_start <= 1'b0;
            conv_req <= 1'b0;
        end
        #1;
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        close_out();
    end
    initial
    begin
        cyc(15);
        @(posedge clk) rst <= 1'b0;
        cyc(1);
        `CHK(pen_n, 1'b1)
        `CHK(ready_n, 1'b1)
        `CHK(dac_rd, 12'h000)
        wr(16'heab5);
        `CHK({dac_cur, dac_full, dac_code}, 10'h3ab)
        wr(16'he120);
        wr(16'h3fff);
        `CHK({dac_cur, dac_full, dac_code}, 10'h012)
        `CHK(dac_rd, 12'h120)
        $display("test dac done");
        @(posedge clk) touch_pin <= 1'b1;
        cyc(4);
        `CHK(pen_n, 1'b0)
        @(posedge clk) touch_pin <= 1'b0;
        cyc(4);
        `CHK(pen_n, 1'b1)
        `CHK(starts, 0)
        $display("test idle touch done");
        wr(16'h1c00);
        `CHK(mode, 2'h3)
        @(posedge clk) touch_pin <= 1'b1;
        cyc(5);
        `CHK(starts, 1)
        `CHK(pen_n, 1'b0)
        @(posedge clk) touch_pin <= 1'b0;
        cyc(4);
        `CHK(conv_busy, 1'b1)
        `CHK(pen_n, 1'b0)
        cyc(6);
        `CHK(pen_n, 1'b1)
        `CHK(ready_n, 1'b0)
        pulse(0);
        `CHK(ready_n, 1'b1)
        $display("test master done");
        wr(16'h1400);
        `CHK(mode, 2'h1)
        pulse(2);
        cyc(12);
        `CHK(ready_n, 1'b0)
        pulse(1);
        `CHK(ready_n, 1'b1)
        $display("test slave done");
        wr(16'h1800);
        `CHK(mode, 2'h2)
        pulse(2);
        @(posedge clk) touch_pin <= 1'b1;
        cyc(4);
        `CHK(conv_busy, 1'b1)
        `CHK(pen_n, 1'b1)
        cyc(8);
        `CHK(pen_n, 1'b0)
        `CHK(starts, 1)
        `CHK(ready_n, 1'b0)
        pulse(0);
        `CHK(ready_n, 1'b1)
        @(posedge clk) touch_pin <= 1'b0;
        cyc(4);
        `CHK(pen_n, 1'b1)
        $display("test slave b done");
        close_out();
    end
endmodule // tb_pid_ctrl
